// >>> psram_async_pkg.sv
// constants and types shared by the pseudo-static memory async cycle logic
package psram_async_pkg;

  // geometry
  localparam int ADDR_W      = 21;
  localparam int DATA_W      = 16;
  localparam int BYTE_W      = 8;
  localparam int PAGE_BITS   = 2;   // four words per page

  // clock rate and documented times
  localparam int CLK_PERIOD_NS   = 4;
  localparam int HIZ_MAX_NS      = 12;  // float after deselect, longest
  localparam int LOWZ_MIN_NS     = 10;  // drive-on after select, least
  localparam int WP_LONG_MIN_NS  = 70;  // write pulse in long write runs
  localparam int LONG_RUN_WRITES = 50;
  localparam int WLRL_MIN_CLK    = 1;

  // least time rounds up, longest rounds down, never below one cycle
  localparam int LOWZ_CYC_RAW = (LOWZ_MIN_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int LOWZ_CYC     = (LOWZ_CYC_RAW < 1) ? 1 : LOWZ_CYC_RAW;
  localparam int HIZ_CYC_RAW  = HIZ_MAX_NS / CLK_PERIOD_NS;
  localparam int HIZ_CYC      = (HIZ_CYC_RAW < 1) ? 1 : HIZ_CYC_RAW;
  localparam int WP_LONG_CYC  = (WP_LONG_MIN_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

  // bus cycle states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } cycle_state_t;

endpackage : psram_async_pkg

// >>> pin_sync.sv
// two-flop synchroniser for a bundle of pin inputs
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] sync
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // first stage feeds only the second
  always_comb begin
    next_meta = pin;
    next_sync = meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      sync <= RESET_VAL;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
    end
  end

endmodule : pin_sync

// >>> psram_async_access_cycles.sv
// async read, page read and write cycles of a 16-bit pseudo-static memory
// Overview of operation
// - array written only at the end of a window with chip select and write strobe both low
// - only enabled byte lanes are updated by a write
// - write ends at first of chip select or write strobe rising
// - single read ignores clock, address strobe; wait stays undriven
// - page reads return up to four words as low address bits change
// - async write ignores clock, address strobe; wait stays undriven
// - latch-type write: clock has no effect if one clock strobe-to-latency
// - outputs float on deselect within three cycles, the 12 ns longest float time, later than the 10 ns least drive-on
module psram_async_access_cycles
  import psram_async_pkg::*;
#(
  parameter int DEPTH_BITS = psram_async_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  // host strobes
  input  wire logic                               chip_select_n,
  input  wire logic                               output_enable_n,
  input  wire logic                               write_enable_n,
  input  wire logic                               upper_byte_enable_n,
  input  wire logic                               lower_byte_enable_n,
  input  wire logic                               address_latch_strobe_n,
  // address and data pins
  input  wire logic [DEPTH_BITS-1:0]              address,
  input  wire logic [psram_async_pkg::DATA_W-1:0] data_in,
  output logic      [psram_async_pkg::DATA_W-1:0] data_out,
  output logic      [psram_async_pkg::DATA_W-1:0] data_oe,
  // wait indicator, never driven in these cycles
  output logic                                    wait_out,
  output logic                                    wait_oe,
  // status
  output logic                                    long_run_seen
);

  import psram_async_pkg::*;

  localparam int CTRL_W = 5;
  localparam int BUS_W  = DEPTH_BITS + DATA_W;
  localparam int WORDS  = 2 ** DEPTH_BITS;
  localparam logic [CTRL_W-1:0] CTRL_IDLE = 5'h1F;
  localparam int RUN_W = $clog2(LONG_RUN_WRITES + 2);
  localparam logic [RUN_W-1:0] RUN_LIMIT = RUN_W'(LONG_RUN_WRITES);

  // synchronised pins; the latch strobe is taken in only to be ignored
  logic [CTRL_W-1:0]     ctrl_s;
  logic [BUS_W-1:0]      bus_s;
  logic                  cs_s;
  logic                  oe_s;
  logic                  we_s;
  logic                  ub_s;
  logic                  lb_s;
  logic [DEPTH_BITS-1:0] addr_s;
  logic [DATA_W-1:0]     din_s;

  pin_sync #(.WIDTH(CTRL_W), .RESET_VAL(CTRL_IDLE)) u_ctrl_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   ({chip_select_n, output_enable_n, write_enable_n,
             upper_byte_enable_n, lower_byte_enable_n}),
    .sync  (ctrl_s)
  );

  pin_sync #(.WIDTH(BUS_W), .RESET_VAL('0)) u_bus_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   ({address, data_in}),
    .sync  (bus_s)
  );

  assign {cs_s, oe_s, we_s, ub_s, lb_s} = ctrl_s;
  assign {addr_s, din_s} = bus_s;

  // array storage in flip-flops
  logic [DATA_W-1:0] mem [WORDS];

  // write capture: data and lanes follow the pins during the overlap
  cycle_state_t          state;
  cycle_state_t          next_state;
  logic [DEPTH_BITS-1:0] wr_addr;
  logic [DEPTH_BITS-1:0] next_wr_addr;
  logic [DATA_W-1:0]     wr_data;
  logic [DATA_W-1:0]     next_wr_data;
  logic                  wr_ub;
  logic                  next_wr_ub;
  logic                  wr_lb;
  logic                  next_wr_lb;
  logic                  commit;
  logic [RUN_W-1:0]      run_cnt;
  logic [RUN_W-1:0]      next_run_cnt;
  logic                  next_long_run;

  // write window is open only while both strobes are low
  logic wr_active;
  assign wr_active = !cs_s && !we_s;

  // state and capture; clock edges only sample, the pins set the timing
  always_comb begin
    next_state    = state;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    next_wr_ub    = wr_ub;
    next_wr_lb    = wr_lb;
    commit        = 1'b0;
    next_run_cnt  = run_cnt;
    next_long_run = long_run_seen;
    unique case (state)
      ST_IDLE: begin
        if (wr_active) begin
          next_state   = ST_WRITE;
          next_wr_addr = addr_s;  // address valid at start
          next_wr_data = din_s;
          next_wr_ub   = !ub_s;
          next_wr_lb   = !lb_s;
        end else if (!cs_s && !oe_s) begin
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        // page reads just follow the address
        if (wr_active) begin
          next_state   = ST_WRITE;
          next_wr_addr = addr_s;
          next_wr_data = din_s;
          next_wr_ub   = !ub_s;
          next_wr_lb   = !lb_s;
        end else if (cs_s || oe_s) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (wr_active) begin
          // last value before the end counts; address held
          next_wr_data = din_s;
          next_wr_ub   = !ub_s;
          next_wr_lb   = !lb_s;
        end else begin
          // first strobe to rise ends the write
          commit     = 1'b1;
          next_state = ST_IDLE;
          if (run_cnt != RUN_LIMIT) begin
            next_run_cnt = run_cnt + RUN_W'(1);
          end else begin
            next_long_run = 1'b1;  // host must stretch pulses
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // only a read between writes breaks the write run
    if (state == ST_READ) begin
      next_run_cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      wr_addr       <= '0;
      wr_data       <= '0;
      wr_ub         <= 1'b0;
      wr_lb         <= 1'b0;
      run_cnt       <= '0;
      long_run_seen <= 1'b0;
    end else begin
      state         <= next_state;
      wr_addr       <= next_wr_addr;
      wr_data       <= next_wr_data;
      wr_ub         <= next_wr_ub;
      wr_lb         <= next_wr_lb;
      run_cnt       <= next_run_cnt;
      long_run_seen <= next_long_run;
    end
  end

  // byte-lane write into the array at end of write
  always_ff @(posedge clk) begin
    if (commit && wr_ub) begin
      mem[wr_addr][DATA_W-1:BYTE_W] <= wr_data[DATA_W-1:BYTE_W];
    end
    if (commit && wr_lb) begin
      mem[wr_addr][BYTE_W-1:0] <= wr_data[BYTE_W-1:0];
    end
  end

  // read driving: lanes on only with select, output enable, no write
  logic [DATA_W-1:0] next_data_out;
  logic [DATA_W-1:0] next_data_oe;
  logic              read_on;

  always_comb begin
    read_on       = !cs_s && !oe_s && we_s;
    next_data_out = mem[addr_s];
    next_data_oe  = '0;
    if (read_on) begin
      next_data_oe[DATA_W-1:BYTE_W] = {BYTE_W{!ub_s}};
      next_data_oe[BYTE_W-1:0]      = {BYTE_W{!lb_s}};
    end
  end

  // release three cycles after deselect (two sync flops and this register), inside the float bound
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out <= '0;
      data_oe  <= '0;
      wait_out <= 1'b0;
      wait_oe  <= 1'b0;
    end else begin
      data_out <= next_data_out;
      data_oe  <= next_data_oe;
      wait_out <= 1'b0;
      wait_oe  <= 1'b0;  // wait undriven
    end
  end

endmodule : psram_async_access_cycles

// >>> psram_async_sva.sv
// bound checker watching the async cycle pins of the memory block
module psram_async_sva
  import psram_async_pkg::*;
(
  // clock and reset
  input wire logic                              clk,
  input wire logic                              rst_n,
  // host strobes
  input wire logic                              chip_select_n,
  input wire logic                              output_enable_n,
  input wire logic                              write_enable_n,
  input wire logic                              upper_byte_enable_n,
  input wire logic                              lower_byte_enable_n,
  // device side
  input wire logic [psram_async_pkg::DATA_W-1:0] data_oe,
  input wire logic                              wait_out,
  input wire logic                              wait_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rd_on;
  // plain read level, sampled later through the pin delay
  assign rd_on = !chip_select_n && !output_enable_n && write_enable_n;
  a_wait_released: assert property (!wait_oe)
    else $error("wait pin driven");
  a_wait_low: assert property (wait_out == 1'b0)
    else $error("wait level not low");
  // four samples cover two sync flops and the output register
  a_write_quiet: assert property (
    !write_enable_n [*4] |-> data_oe == '0) else $error("drive in write");
  a_word_lanes: assert property (
    (rd_on && !upper_byte_enable_n && !lower_byte_enable_n) [*4]
    |-> data_oe == 16'hFFFF) else $error("word lanes wrong");
  a_upper_lane: assert property (
    (rd_on && !upper_byte_enable_n && lower_byte_enable_n) [*4]
    |-> data_oe == 16'hFF00) else $error("upper lane wrong");
  a_lower_lane: assert property (
    (rd_on && upper_byte_enable_n && !lower_byte_enable_n) [*4]
    |-> data_oe == 16'h00FF) else $error("lower lane wrong");
  a_deselect_float: assert property (
    $rose(chip_select_n) |-> ##[1:3] data_oe == '0) else $error("no float");
  a_drive_cause: assert property (
    data_oe != '0 |-> $past(rd_on, 3)) else $error("drive without read");
endmodule : psram_async_sva

bind psram_async_access_cycles psram_async_sva u_sva (.clk, .rst_n,
  .chip_select_n, .output_enable_n, .write_enable_n, .upper_byte_enable_n,
  .lower_byte_enable_n, .data_oe, .wait_out, .wait_oe);

// >>> psram_host_model.sv
// host controller model issuing async read and write cycles
module psram_host_model
  import psram_async_pkg::*;
#(
  parameter int AW = 6
) (
  // clock
  input  wire logic              clk,
  // strobes
  output logic                   chip_select_n,
  output logic                   output_enable_n,
  output logic                   write_enable_n,
  output logic                   upper_byte_enable_n,
  output logic                   lower_byte_enable_n,
  output logic                   address_latch_strobe_n,
  // address and data
  output logic [AW-1:0]          address,
  output logic [DATA_W-1:0]      data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {chip_select_n, output_enable_n, write_enable_n} = 3'h7;
    {upper_byte_enable_n, lower_byte_enable_n, address_latch_strobe_n} = 3'h7;
    address = '0;
    data_in = '0;
  end
  // release all strobes; a released data bus shows the inverse
  task automatic idle;
    @(posedge clk);
    {chip_select_n, output_enable_n, write_enable_n} <= 3'h7;
    {upper_byte_enable_n, lower_byte_enable_n, address_latch_strobe_n} <= 3'h7;
    data_in <= ~data_in;
    repeat (3) @(posedge clk);
  endtask : idle
  // mode 0 ends by write strobe, 1 by select, 2 never selects
  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d,
                    input logic [1:0] ln, input int mode);
    @(posedge clk);
    address <= a;
    data_in <= d;
    {upper_byte_enable_n, lower_byte_enable_n} <= ln;
    {chip_select_n, write_enable_n} <= {mode == 2, 1'b0};
    address_latch_strobe_n <= 1'b0;
    // long pulse always, so runs past fifty writes stay legal
    repeat (WP_LONG_CYC) @(posedge clk);
    if (mode == 1) chip_select_n <= 1'b1;
    else write_enable_n <= 1'b1;
    repeat (3) @(posedge clk);
    idle();
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, input logic [1:0] ln);
    @(posedge clk);
    address <= a;
    {upper_byte_enable_n, lower_byte_enable_n} <= ln;
    {chip_select_n, output_enable_n} <= 2'h0;
    address_latch_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : rd
endmodule : psram_host_model

// >>> psram_async_access_cycles_tb_top.sv
// self-checking bench for the async access cycle block
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module psram_async_access_cycles_tb_top
  import psram_async_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  int          mismatches = 0;
  int          checks_done = 0;
  logic        clk, rst_n, chip_select_n, output_enable_n, write_enable_n;
  logic        upper_byte_enable_n, lower_byte_enable_n;
  logic        address_latch_strobe_n, wait_out, wait_oe, long_run_seen;
  logic [5:0]  address;
  logic [15:0] data_in, data_out, data_oe;
  psram_async_access_cycles #(.DEPTH_BITS(6)) DUT (.clk, .rst_n,
    .chip_select_n, .output_enable_n, .write_enable_n, .upper_byte_enable_n,
    .lower_byte_enable_n, .address_latch_strobe_n, .address, .data_in,
    .data_out, .data_oe, .wait_out, .wait_oe, .long_run_seen);
  psram_host_model #(.AW(6)) host (.clk, .chip_select_n, .output_enable_n,
    .write_enable_n, .upper_byte_enable_n, .lower_byte_enable_n,
    .address_latch_strobe_n, .address, .data_in);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // read one address, compare only the lanes asked for
  task automatic check_rd(input logic [5:0] a, input logic [1:0] ln,
                          input logic [15:0] exp, input bit last);
    logic [15:0] m;
    m = {{8{~ln[1]}}, {8{~ln[0]}}};
    host.rd(a, ln);
    @(negedge clk);
    `CHK(data_oe, m)
    `CHK(data_out & m, exp & m)
    if (last) begin
      host.idle();
      @(negedge clk);
      `CHK(data_oe, 16'h0000)
    end
  endtask : check_rd
  task automatic t_reset;
    @(negedge clk);
    `CHK({data_oe, wait_oe, long_run_seen}, 18'h0)
    `CHK({data_out, wait_out}, 17'h0)
  endtask : t_reset
  // fifty writes are allowed, the next one flags the long run
  task automatic t_long_run;
    for (int i = 0; i < LONG_RUN_WRITES; i++) host.wr(0, 16'(i), 0, 0);
    @(negedge clk);
    `CHK(long_run_seen, 1'b0)
    host.wr(6'h00, 16'h0051, 2'b00, 0);
    @(negedge clk);
    `CHK(long_run_seen, 1'b1)
  endtask : t_long_run
  task automatic t_lanes;
    host.wr(6'h05, 16'h1234, 2'b00, 0);
    check_rd(6'h05, 2'b00, 16'h1234, 1);
    host.wr(6'h05, 16'hABCD, 2'b01, 1);
    check_rd(6'h05, 2'b00, 16'hAB34, 1);
    host.wr(6'h05, 16'h99EF, 2'b10, 0);
    check_rd(6'h05, 2'b10, 16'h00EF, 1);
    host.wr(6'h05, 16'h0000, 2'b00, 2);
    check_rd(6'h05, 2'b00, 16'hABEF, 1);
  endtask : t_lanes
  // select stays low while only the low address bits step
  task automatic t_page;
    for (int i = 0; i < 4; i++) host.wr(6'(8 + i), 16'(i * 257), 0, 0);
    for (int i = 0; i < 4; i++)
      check_rd(6'(8 + i), 2'b01, 16'(i * 257), i == 3);
  endtask : t_page
  initial begin
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_long_run();
    t_lanes();
    t_page();
    give_verdict();
  end
  // traffic takes under 2000 cycles; allow well beyond that
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule : psram_async_access_cycles_tb_top
